// File: hdl/ehc_pkg.sv
// constants shared by the host command port design
package ehc_pkg;
  // host i/o port decode
  localparam logic [7:0] HOST_DATA_PORT_ADDR   = 8'h62;
  localparam logic [7:0] HOST_CMD_STAT_ADDR    = 8'h66;
  // controller-space smbus window
  localparam logic [7:0] SMB_BASE              = 8'h40;
  localparam logic [7:0] SMB_PROTOCOL_OFF      = 8'h40;
  localparam logic [7:0] SMB_TARGET_ADDR_OFF   = 8'h42;
  localparam logic [7:0] SMB_COMMAND_CODE_OFF  = 8'h43;
  localparam logic [7:0] SMBUS_DATA_BYTES_LOW_OFF      = 8'h44;
  localparam logic [7:0] SMBUS_DATA_BYTES_HIGH_OFF     = 8'h45;
  localparam logic [7:0] SMB_PROTO_READ_WORD   = 8'h07;
  localparam logic [7:0] SMB_RESET_VALUE       = 8'h00;
  // host command bytes
  localparam logic [7:0] CMD_SPACE_READ        = 8'h80;
  localparam logic [7:0] CMD_SPACE_WRITE       = 8'h81;
  localparam logic [7:0] CMD_BURST_ENABLE      = 8'h82;
  localparam logic [7:0] CMD_BURST_DISABLE     = 8'h83;
  localparam logic [7:0] CMD_QUERY             = 8'h84;
  // notification header for smbus completion
  localparam logic [7:0] NOTIFY_SMB_DONE       = 8'h21;
  localparam logic [7:0] NOTIFY_NONE           = 8'h00;
  // status register bit positions
  localparam int         STAT_OBF_BIT          = 0;
  localparam int         STAT_IBF_BIT          = 1;
  localparam int         STAT_BURST_BIT        = 4;
  localparam int         STAT_EVENT_BIT        = 5;
  localparam logic [7:0] STAT_RESET            = 8'h00;
  localparam logic [7:0] BYTE_RESET            = 8'h00;
  // pin synchroniser depth
  localparam int         SYNC_STAGES           = 2;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RADR  = 2'b10,
    ST_WADR  = 2'b01,
    ST_WDAT  = 2'b11
  } ehc_seq_t;

  typedef enum logic {
    SM_IDLE  = 1'b0,
    SM_BUSY  = 1'b1
  } ehc_smb_t;
endpackage

// File: hdl/ehc_sync.sv
// two-flop synchroniser for host-side pins
`timescale 1ns/1ps
module ehc_sync #(
  parameter int WIDTH = 18
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import ehc_pkg::*;

  logic [WIDTH-1:0] meta_ff;

  initial begin
    if (WIDTH < 1 || SYNC_STAGES != 2) begin
      $error("ehc_sync: unsupported width or depth");
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule

// File: hdl/ehc_space_ram.sv
// controller-space byte memory, one write and one read port
`timescale 1ns/1ps
module ehc_space_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  initial begin
    if (AW < 1 || DW < 1) begin
      $error("ehc_space_ram: bad geometry");
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// File: hdl/ehc_host_command_port.sv
// host command/data port of the embedded controller with smbus window
//
// Overview of operation
// - command/status port decoded at 66h
// - data port decoded at 62h
// - smbus window base 40h, protocol at base
// - target address base+2, command code base+3
// - word read result at base+4 and base+5
// - protocol write starts transaction; 07h word read
// - completion reported by query header 21h
// - command 81h starts controller-space write
// - data stored only after final byte arrives
// - interrupt after each byte taken from buffer
// - command 82h sets burst flag, raises interrupt
// - bursting with empty buffer reads 10h
// - command 83h clears status to 00h
// - burst off and protocol non-zero starts transaction
// - completion sets event flag 20h, raises interrupt
// - command 84h returns pending notification header
// - command 80h plus address returns addressed byte
`timescale 1ns/1ps
module ehc_host_command_port #(
  parameter int AW = 8
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [7:0] hst_addr,
  input  wire logic [7:0] hst_wdata,
  input  wire logic       hst_wr,
  input  wire logic       hst_rd,
  output logic      [7:0] hst_rdata_ff,
  output logic            system_control_interrupt_ff,
  output logic            smb_start_ff,
  output logic      [7:0] smbus_protocol_ff,
  output logic      [7:0] smbus_target_address_ff,
  output logic      [7:0] smbus_command_code_ff,
  input  wire logic       smb_done,
  input  wire logic [7:0] smb_rx_low,
  input  wire logic [7:0] smb_rx_high
);
  import ehc_pkg::*;

  initial begin
    if (AW != 8) begin
      $error("ehc_host_command_port: controller space must be 8-bit addressed");
    end
  end

  // ***********************************************************
  // host pin capture
  // ***********************************************************
  logic [17:0] pin_sync;
  logic [7:0]  s_addr;
  logic [7:0]  s_wdata;
  logic        s_wr;
  logic        s_rd;
  logic        wr_prev_ff;
  logic        rd_prev_ff;
  logic        wr_edge;
  logic        rd_edge;

  ehc_sync #(.WIDTH(18)) u_sync (
    .clk  (clk),
    .srst (srst),
    .din  ({hst_addr, hst_wdata, hst_wr, hst_rd}),
    .dout (pin_sync)
  );

  assign s_addr  = pin_sync[17:10];
  assign s_wdata = pin_sync[9:2];
  assign s_wr    = pin_sync[1];
  assign s_rd    = pin_sync[0];

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_prev_ff <= 1'b0;
      rd_prev_ff <= 1'b0;
    end else begin
      wr_prev_ff <= s_wr;
      rd_prev_ff <= s_rd;
    end
  end

  assign wr_edge = s_wr && !wr_prev_ff;
  assign rd_edge = s_rd && !rd_prev_ff;

  logic host_wr_data;
  logic host_wr_cmd;
  logic host_rd_data;

  assign host_wr_data = wr_edge && (s_addr == HOST_DATA_PORT_ADDR);
  assign host_wr_cmd  = wr_edge && (s_addr == HOST_CMD_STAT_ADDR);
  assign host_rd_data = rd_edge && (s_addr == HOST_DATA_PORT_ADDR);

  // ***********************************************************
  // input buffer
  // ***********************************************************
  logic [7:0] input_buffer_register_ff;
  logic       input_buffer_full_ff;
  logic       ibuf_is_cmd_ff;
  logic       take;

  // the sequencer consumes a pending byte in the cycle it is seen
  assign take = input_buffer_full_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      input_buffer_register_ff <= BYTE_RESET;
      input_buffer_full_ff     <= 1'b0;
      ibuf_is_cmd_ff           <= 1'b0;
    end else if ((host_wr_data || host_wr_cmd) && !input_buffer_full_ff) begin
      input_buffer_register_ff <= s_wdata;
      input_buffer_full_ff     <= 1'b1;
      ibuf_is_cmd_ff           <= host_wr_cmd;
    end else if (take) begin
      input_buffer_full_ff     <= 1'b0;
    end
  end

  // ***********************************************************
  // command sequencer
  // ***********************************************************
  ehc_seq_t   seq_ff;
  ehc_seq_t   nxt_seq;
  logic [7:0] space_addr_ff;
  logic       cmd_take;
  logic       dat_take;
  logic [7:0] input_buffer_register;

  assign input_buffer_register      = input_buffer_register_ff;
  assign cmd_take = take && ibuf_is_cmd_ff;
  assign dat_take = take && !ibuf_is_cmd_ff;

  always_comb begin
    nxt_seq = seq_ff;
    if (cmd_take) begin
      case (input_buffer_register)
        CMD_SPACE_READ:  nxt_seq = ST_RADR;
        CMD_SPACE_WRITE: nxt_seq = ST_WADR;
        default:         nxt_seq = ST_IDLE;
      endcase
    end else if (dat_take) begin
      case (seq_ff)
        ST_WADR: nxt_seq = ST_WDAT;
        ST_RADR: nxt_seq = ST_IDLE;
        ST_WDAT: nxt_seq = ST_IDLE;
        default: nxt_seq = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seq_ff <= ST_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      space_addr_ff <= BYTE_RESET;
    end else if (dat_take && seq_ff == ST_WADR) begin
      space_addr_ff <= input_buffer_register;
    end
  end

  // ***********************************************************
  // controller space: smbus window in flops, rest in memory
  // ***********************************************************
  logic       space_we;
  logic [7:0] ram_rdata;
  logic [7:0] space_rdata;
  logic [7:0] smbus_data_low_ff;
  logic [7:0] smbus_data_high_ff;
  logic       win_hit;

  assign space_we = dat_take && seq_ff == ST_WDAT;

  function automatic logic is_window(input logic [7:0] a);
    is_window = (a == SMB_PROTOCOL_OFF) || (a == SMB_TARGET_ADDR_OFF) ||
                (a == SMB_COMMAND_CODE_OFF) || (a == SMBUS_DATA_BYTES_LOW_OFF) ||
                (a == SMBUS_DATA_BYTES_HIGH_OFF);
  endfunction

  assign win_hit = is_window(input_buffer_register);

  ehc_space_ram #(.AW(AW), .DW(8)) u_ram (
    .clk   (clk),
    .we    (space_we && !is_window(space_addr_ff)),
    .waddr (space_addr_ff),
    .wdata (input_buffer_register),
    .raddr (input_buffer_register),
    .rdata (ram_rdata)
  );

  always_comb begin
    case (input_buffer_register)
      SMB_PROTOCOL_OFF:     space_rdata = smbus_protocol_ff;
      SMB_TARGET_ADDR_OFF:  space_rdata = smbus_target_address_ff;
      SMB_COMMAND_CODE_OFF: space_rdata = smbus_command_code_ff;
      SMBUS_DATA_BYTES_LOW_OFF:     space_rdata = smbus_data_low_ff;
      SMBUS_DATA_BYTES_HIGH_OFF:    space_rdata = smbus_data_high_ff;
      default:              space_rdata = win_hit ? BYTE_RESET : ram_rdata;
    endcase
  end

  // ***********************************************************
  // smbus transaction engine handshake
  // ***********************************************************
  ehc_smb_t smb_ff;
  logic     burst_ff;
  logic     smb_finish;

  assign smb_finish = smb_ff == SM_BUSY && smb_done;

  always_ff @(posedge clk) begin
    if (srst) begin
      smb_ff       <= SM_IDLE;
      smb_start_ff <= 1'b0;
    end else begin
      smb_start_ff <= 1'b0;
      case (smb_ff)
        SM_IDLE: begin
          if (!burst_ff && smbus_protocol_ff != SMB_RESET_VALUE) begin
            smb_ff       <= SM_BUSY;
            smb_start_ff <= 1'b1;
          end
        end
        SM_BUSY: begin
          if (smb_done) begin
            smb_ff <= SM_IDLE;
          end
        end
        default: smb_ff <= SM_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      smbus_protocol_ff       <= SMB_RESET_VALUE;
      smbus_target_address_ff <= SMB_RESET_VALUE;
      smbus_command_code_ff   <= SMB_RESET_VALUE;
      smbus_data_low_ff       <= SMB_RESET_VALUE;
      smbus_data_high_ff      <= SMB_RESET_VALUE;
    end else begin
      if (smb_finish) begin
        smbus_protocol_ff  <= SMB_RESET_VALUE;
        smbus_data_low_ff  <= smb_rx_low;
        smbus_data_high_ff <= smb_rx_high;
      end
      if (space_we) begin
        case (space_addr_ff)
          SMB_PROTOCOL_OFF:     smbus_protocol_ff       <= input_buffer_register;
          SMB_TARGET_ADDR_OFF:  smbus_target_address_ff <= input_buffer_register;
          SMB_COMMAND_CODE_OFF: smbus_command_code_ff   <= input_buffer_register;
          SMBUS_DATA_BYTES_LOW_OFF:     smbus_data_low_ff       <= input_buffer_register;
          SMBUS_DATA_BYTES_HIGH_OFF:    smbus_data_high_ff      <= input_buffer_register;
          default:              ;
        endcase
      end
    end
  end

  // ***********************************************************
  // status flags, output buffer and interrupt
  // ***********************************************************
  logic [7:0] output_buffer_register_ff;
  logic       output_buffer_full_ff;
  logic       event_pending_flag_ff;
  logic [7:0] controller_status_register;
  logic       obf_load;
  logic       do_bd;
  logic       do_query;

  assign do_bd    = cmd_take && input_buffer_register == CMD_BURST_DISABLE;
  assign do_query = cmd_take && input_buffer_register == CMD_QUERY;
  assign obf_load = do_query || (dat_take && seq_ff == ST_RADR);

  always_ff @(posedge clk) begin
    if (srst) begin
      burst_ff <= 1'b0;
    end else if (cmd_take && input_buffer_register == CMD_BURST_ENABLE) begin
      burst_ff <= 1'b1;
    end else if (do_bd) begin
      burst_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      event_pending_flag_ff <= 1'b0;
    end else if (smb_finish) begin
      event_pending_flag_ff <= 1'b1;
    end else if (do_query || do_bd) begin
      event_pending_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      output_buffer_register_ff <= BYTE_RESET;
      output_buffer_full_ff     <= 1'b0;
    end else if (obf_load) begin
      output_buffer_register_ff <= do_query ?
        (event_pending_flag_ff ? NOTIFY_SMB_DONE : NOTIFY_NONE) : space_rdata;
      output_buffer_full_ff     <= 1'b1;
    end else if (host_rd_data || do_bd) begin
      output_buffer_full_ff     <= 1'b0;
    end
  end

  always_comb begin
    controller_status_register                 = STAT_RESET;
    controller_status_register[STAT_OBF_BIT]   = output_buffer_full_ff;
    controller_status_register[STAT_IBF_BIT]   = input_buffer_full_ff;
    controller_status_register[STAT_BURST_BIT] = burst_ff;
    controller_status_register[STAT_EVENT_BIT] = event_pending_flag_ff;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      hst_rdata_ff <= BYTE_RESET;
    end else if (s_addr == HOST_CMD_STAT_ADDR) begin
      hst_rdata_ff <= controller_status_register;
    end else begin
      hst_rdata_ff <= output_buffer_register_ff;
    end
  end

  // one pulse per cycle with a consumed byte or a completion
  always_ff @(posedge clk) begin
    if (srst) begin
      system_control_interrupt_ff <= 1'b0;
    end else begin
      system_control_interrupt_ff <= take || smb_finish;
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  property p_ibf_set;
    @(posedge clk) disable iff (srst)
      (host_wr_cmd || host_wr_data) && !input_buffer_full_ff |=> input_buffer_full_ff;
  endproperty
  a_ibf_set: assert property (p_ibf_set) else $error("write not latched");

  property p_take_irq;
    @(posedge clk) disable iff (srst)
      input_buffer_full_ff |=> system_control_interrupt_ff;
  endproperty
  a_take_irq: assert property (p_take_irq) else $error("no interrupt on take");

  property p_burst_on;
    @(posedge clk) disable iff (srst)
      cmd_take && input_buffer_register == CMD_BURST_ENABLE |=> burst_ff ##1
      (hst_rdata_ff[STAT_BURST_BIT] || $past(s_addr) != HOST_CMD_STAT_ADDR);
  endproperty
  a_burst_on: assert property (p_burst_on) else $error("burst not set");

  property p_status_burst;
    @(posedge clk) disable iff (srst)
      burst_ff && !input_buffer_full_ff && !output_buffer_full_ff && !event_pending_flag_ff
      && s_addr == HOST_CMD_STAT_ADDR |=> hst_rdata_ff == 8'h10;
  endproperty
  a_status_burst: assert property (p_status_burst) else $error("burst status wrong");

  property p_burst_off;
    @(posedge clk) disable iff (srst)
      do_bd && !smb_finish && !((host_wr_cmd || host_wr_data) && !input_buffer_full_ff)
      |=> controller_status_register == STAT_RESET;
  endproperty
  a_burst_off: assert property (p_burst_off) else $error("status not cleared");

  property p_query;
    @(posedge clk) disable iff (srst)
      do_query && event_pending_flag_ff |=> output_buffer_register_ff == NOTIFY_SMB_DONE &&
      output_buffer_full_ff;
  endproperty
  a_query: assert property (p_query) else $error("bad notification header");

  property p_write_last;
    @(posedge clk) disable iff (srst)
      $changed(smbus_target_address_ff) |->
      $past(space_we) && $past(space_addr_ff) == SMB_TARGET_ADDR_OFF;
  endproperty
  a_write_last: assert property (p_write_last) else $error("early space write");

  property p_start;
    @(posedge clk) disable iff (srst)
      smb_ff == SM_IDLE && !burst_ff && smbus_protocol_ff != SMB_RESET_VALUE |=> smb_start_ff
      ##1 !smb_start_ff;
  endproperty
  a_start: assert property (p_start) else $error("transaction not started");

  property p_done;
    @(posedge clk) disable iff (srst)
      smb_finish |=> event_pending_flag_ff && system_control_interrupt_ff &&
      smbus_data_low_ff == $past(smb_rx_low);
  endproperty
  a_done: assert property (p_done) else $error("completion not flagged");

  property p_read;
    @(posedge clk) disable iff (srst)
      dat_take && seq_ff == ST_RADR |=> output_buffer_full_ff && seq_ff == ST_IDLE;
  endproperty
  a_read: assert property (p_read) else $error("read not returned");

  c_write_seq: cover property (@(posedge clk) disable iff (srst) space_we);
  c_query:     cover property (@(posedge clk) disable iff (srst) do_query);
  c_smb_done:  cover property (@(posedge clk) disable iff (srst) smb_finish);
endmodule

// File: tb/ehc_host_model.sv
// host processor model driving the command and data ports
`timescale 1ns/1ps
module ehc_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] hst_rdata_ff,
  input  wire logic       system_control_interrupt_ff,
  output logic      [7:0] hst_addr,
  output logic      [7:0] hst_wdata,
  output logic            hst_wr,
  output logic            hst_rd,
  output logic            res_stb,
  output logic            res_kind,
  output logic      [7:0] res_val
);
  localparam int DLY = 1;
  localparam int WIN = 24;

  initial begin
    hst_addr  = 8'h00;
    hst_wdata = 8'h00;
    hst_wr    = 1'b0;
    hst_rd    = 1'b0;
    res_stb   = 1'b0;
    res_kind  = 1'b0;
    res_val   = 8'h00;
  end

  // **************************************
  // bus cycles
  // **************************************
  task automatic emit(input logic k, input logic [7:0] v);
    res_kind = k;
    res_val  = v;
    res_stb  = 1'b1;
    @(posedge clk);
    #DLY;
    res_stb = 1'b0;
  endtask

  task automatic count_sci(input int c, input int drop, input logic [7:0] a);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < c; i++) begin
      @(posedge clk);
      if (system_control_interrupt_ff === 1'b1)
        n = n + 8'h01;
      if (i == drop) begin
        #DLY;
        hst_wr    = 1'b0;
        hst_addr  = ~a;
        hst_wdata = ~hst_wdata;
      end
    end
    #DLY;
    emit(1'b1, n);
  endtask

  // next byte only after a full settle window
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    hst_addr  = a;
    hst_wdata = d;
    repeat (4) @(posedge clk);
    #DLY;
    hst_wr = 1'b1;
    count_sci(WIN, 5, a);
  endtask

  task automatic io_wait(input int c);
    count_sci(c, -1, hst_addr);
  endtask

  task automatic io_rd(input logic [7:0] a);
    logic [7:0] v;
    hst_addr = a;
    repeat (4) @(posedge clk);
    #DLY;
    hst_rd = 1'b1;
    repeat (4) @(posedge clk);
    v = hst_rdata_ff;
    #DLY;
    hst_rd = 1'b0;
    repeat (3) @(posedge clk);
    #DLY;
    hst_addr = ~a;
    emit(1'b0, v);
  endtask
endmodule

// File: tb/ehc_host_command_port_tb.sv
// self-checking bench for the host command port
`timescale 1ns/1ps
module ehc_host_command_port_tb;
  import ehc_pkg::*;
  typedef struct packed {
    logic       k;
    logic [7:0] v;
  } ehc_exp_t;
  localparam int         DLY = 1;
  localparam logic [7:0] CP  = HOST_CMD_STAT_ADDR;
  localparam logic [7:0] DP  = HOST_DATA_PORT_ADDR;
  logic        clk, srst, hst_wr, hst_rd, system_control_interrupt, smb_start_ff, smb_done;
  logic        res_stb, res_kind, pk_stb;
  logic [7:0]  hst_addr, hst_wdata, hst_rdata_ff, prot, tgt, ccode, res_val;
  logic [7:0]  smb_rx_low, smb_rx_high, exp_lo, exp_hi, st, starts, pk_val, ra, rv;
  logic [31:0] seed = 32'h6A2F;
  int          eng_delay = 1;
  int          miscompares = 0;
  int          comparisons = 0;
  ehc_exp_t    exp_q[$];

  initial clk = 1'b0;
  always #25 clk = ~clk;

  ehc_host_command_port ehc_host_command_port_i (
    .clk(clk), .srst(srst), .hst_addr(hst_addr), .hst_wdata(hst_wdata),
    .hst_wr(hst_wr), .hst_rd(hst_rd), .hst_rdata_ff(hst_rdata_ff),
    .system_control_interrupt_ff(system_control_interrupt), .smb_start_ff(smb_start_ff),
    .smbus_protocol_ff(prot), .smbus_target_address_ff(tgt),
    .smbus_command_code_ff(ccode), .smb_done(smb_done),
    .smb_rx_low(smb_rx_low), .smb_rx_high(smb_rx_high));

  ehc_host_model ehc_host_model_i (
    .clk(clk), .hst_rdata_ff(hst_rdata_ff), .system_control_interrupt_ff(system_control_interrupt),
    .hst_addr(hst_addr), .hst_wdata(hst_wdata), .hst_wr(hst_wr), .hst_rd(hst_rd),
    .res_stb(res_stb), .res_kind(res_kind), .res_val(res_val));

  // **************************************
  // checking
  // **************************************
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_count(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: pulses got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic take(input logic k, input logic [7:0] v);
    ehc_exp_t e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : '{k: k, v: 8'hXX};
    if (k)
      compare_count(v, e.v);
    else
      compare_byte(v, e.v);
  endtask

  always @(posedge clk) begin
    if (res_stb === 1'b1)
      take(res_kind, res_val);
    if (pk_stb === 1'b1)
      take(1'b0, pk_val);
  end

  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // **************************************
  // stimulus
  // **************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] n);
    exp_q.push_back('{k: 1'b1, v: n});
    ehc_host_model_i.io_wr(a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back('{k: 1'b0, v: e});
    ehc_host_model_i.io_rd(a);
  endtask

  task automatic peek(input logic [7:0] o, input logic [7:0] e);
    exp_q.push_back('{k: 1'b0, v: e});
    pk_val = o;
    pk_stb = 1'b1;
    @(posedge clk);
    #DLY;
    pk_stb = 1'b0;
  endtask

  task automatic space_wr(input logic [7:0] a, input logic [7:0] d);
    rd(CP, st);
    wr(CP, CMD_SPACE_WRITE, 8'h01);
    rd(CP, st);
    wr(DP, a, 8'h01);
    rd(CP, st);
    wr(DP, d, 8'h01);
  endtask

  task automatic space_rd(input logic [7:0] a, input logic [7:0] d);
    rd(CP, st);
    wr(CP, CMD_SPACE_READ, 8'h01);
    rd(CP, st);
    wr(DP, a, 8'h01);
    rd(CP, st | 8'h01);
    rd(DP, d);
    rd(CP, st);
  endtask

  task automatic query(input logic [7:0] hdr);
    wr(CP, CMD_QUERY, 8'h01);
    rd(CP, 8'h01);
    rd(DP, hdr);
    rd(CP, 8'h00);
  endtask

  // far-side engine, prompt or slow by eng_delay
  initial begin
    forever begin
      @(posedge clk);
      if (smb_start_ff === 1'b1) begin
        starts = starts + 8'h01;
        repeat (eng_delay) @(posedge clk);
        #DLY;
        exp_lo      = rnd();
        exp_hi      = rnd();
        smb_rx_low  = exp_lo;
        smb_rx_high = exp_hi;
        smb_done    = 1'b1;
        @(posedge clk);
        #DLY;
        smb_done    = 1'b0;
        smb_rx_low  = ~exp_lo;
        smb_rx_high = ~exp_hi;
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  initial begin
    srst        = 1'b1;
    smb_done    = 1'b0;
    smb_rx_low  = 8'h00;
    smb_rx_high = 8'h00;
    pk_stb      = 1'b0;
    pk_val      = 8'h00;
    st          = 8'h00;
    starts      = 8'h00;
    repeat (5) @(posedge clk);
    #DLY;
    srst = 1'b0;
    peek(prot, SMB_RESET_VALUE);
    peek(tgt, SMB_RESET_VALUE);
    peek(ccode, SMB_RESET_VALUE);
    rd(CP, STAT_RESET);
    wr(CP, CMD_BURST_ENABLE, 8'h01);
    st = 8'h10;
    rd(CP, st);
    wr(CP, CMD_SPACE_WRITE, 8'h01);
    rd(CP, st);
    wr(DP, SMB_TARGET_ADDR_OFF, 8'h01);
    peek(tgt, SMB_RESET_VALUE);
    rd(CP, st);
    wr(DP, 8'h12, 8'h01);
    peek(tgt, 8'h12);
    space_wr(SMB_COMMAND_CODE_OFF, 8'h13);
    peek(ccode, 8'h13);
    ra = rnd() & 8'h3F;
    rv = rnd();
    space_wr(ra, rv);
    space_rd(ra, rv);
    space_rd(SMB_TARGET_ADDR_OFF, 8'h12);
    wr(8'h64, 8'h55, 8'h00);
    space_wr(SMB_PROTOCOL_OFF, SMB_PROTO_READ_WORD);
    peek(prot, SMB_PROTO_READ_WORD);
    peek(starts, 8'h00);
    rd(CP, st);
    wr(CP, CMD_BURST_DISABLE, 8'h02);
    st = 8'h00;
    peek(starts, 8'h01);
    rd(CP, 8'h20);
    query(NOTIFY_SMB_DONE);
    peek(prot, SMB_RESET_VALUE);
    space_rd(SMBUS_DATA_BYTES_LOW_OFF, exp_lo);
    space_rd(SMBUS_DATA_BYTES_HIGH_OFF, exp_hi);
    query(NOTIFY_NONE);
    smb_rx_low = ~exp_lo;
    smb_done   = 1'b1;
    @(posedge clk);
    #DLY;
    smb_done = 1'b0;
    rd(CP, 8'h00);
    space_rd(SMBUS_DATA_BYTES_LOW_OFF, exp_lo);
    eng_delay = 150 + int'(rnd() & 8'h3F);
    space_wr(SMB_PROTOCOL_OFF, SMB_PROTO_READ_WORD);
    exp_q.push_back('{k: 1'b1, v: 8'h01});
    ehc_host_model_i.io_wait(300);
    peek(starts, 8'h02);
    rd(CP, 8'h20);
    query(NOTIFY_SMB_DONE);
    space_rd(SMBUS_DATA_BYTES_LOW_OFF, exp_lo);
    space_rd(SMBUS_DATA_BYTES_HIGH_OFF, exp_hi);
    end_of_test();
  end
endmodule
